// ---- logic/kpc_button.sv ----
`default_nettype none
module kpc_button import kpc_pkg::*; #(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int DB_TICKS = DEBOUNCE_TICKS,
   parameter int HLD_TICKS = HOLD_TICKS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_button_n,
   kpc_evt_if.btn_src evt
);
   localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   localparam int DW = $clog2(DB_TICKS + 1);
   localparam int HW = $clog2(HLD_TICKS + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
   localparam logic [DW-1:0] DB_LAST = DW'(DB_TICKS - 1);
   localparam logic [HW-1:0] HLD_LAST = HW'(HLD_TICKS - 1);

   generate
      if (TICK_CYC < 1 || DB_TICKS < 1 || HLD_TICKS < 1) begin : g_bad
         $error("kpc_button counts must be at least one");
      end
   endgenerate

   logic [1:0] sync_reg, sync_next;
   logic [TW-1:0] tick_reg, tick_next;
   logic [DW-1:0] db_reg, db_next;
   logic [HW-1:0] hold_reg, hold_next;
   logic pressed_reg, pressed_next;
   logic long_done_reg, long_done_next;
   logic short_reg, short_next;
   logic long_reg, long_next;
   logic tick;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      sync_next = {sync_reg[0], ~power_button_n};
      tick = (tick_reg == TICK_LAST);
      tick_next = tick ? '0 : tick_reg + 1'b1;
      db_next = db_reg;
      pressed_next = pressed_reg;
      hold_next = hold_reg;
      long_done_next = long_done_reg;
      short_next = 1'b0;
      long_next = 1'b0;
      if (sync_reg[1] == pressed_reg) begin
         db_next = '0;
      end else if (tick) begin
         if (db_reg == DB_LAST) begin
            db_next = '0;
            pressed_next = sync_reg[1];
         end else begin
            db_next = db_reg + 1'b1;
         end
      end
      if (pressed_next && !pressed_reg) begin
         hold_next = '0;
         long_done_next = 1'b0;
      end else if (pressed_reg && tick && !long_done_reg) begin
         if (hold_reg == HLD_LAST) begin
            long_next = 1'b1;
            long_done_next = 1'b1;
         end else begin
            hold_next = hold_reg + 1'b1;
         end
      end
      if (!pressed_next && pressed_reg && !long_done_reg) begin
         short_next = 1'b1;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_reg <= '0;
         tick_reg <= '0;
         db_reg <= '0;
         hold_reg <= '0;
         pressed_reg <= 1'b0;
         long_done_reg <= 1'b0;
         short_reg <= 1'b0;
         long_reg <= 1'b0;
      end else begin
         sync_reg <= sync_next;
         tick_reg <= tick_next;
         db_reg <= db_next;
         hold_reg <= hold_next;
         pressed_reg <= pressed_next;
         long_done_reg <= long_done_next;
         short_reg <= short_next;
         long_reg <= long_next;
      end
   end

   assign evt.short_press = short_reg;
   assign evt.long_press = long_reg;
   assign evt.pressed = pressed_reg;
endmodule
`default_nettype wire

// ---- logic/kpc_evt_if.sv ----
`default_nettype none
interface kpc_evt_if;
   import kpc_pkg::*;
   logic short_press;
   logic long_press;
   logic pressed;
   kpc_key_t key_state;
   logic forced_entry;
   modport btn_src (output short_press, output long_press, output pressed);
   modport key_src (output key_state, output forced_entry);
   modport sink (input short_press, input long_press, input pressed,
                 input key_state, input forced_entry);
endinterface
`default_nettype wire

// ---- logic/kpc_keyswitch.sv ----
`default_nettype none
module kpc_keyswitch import kpc_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] keyswitch_pos,
   kpc_evt_if.key_src evt
);
   logic [1:0] s1_reg, s1_next;
   logic [1:0] s2_reg, s2_next;
   logic [1:0] last_reg, last_next;
   kpc_key_t key_reg, key_next;
   logic entry_reg, entry_next;

   // ****************************************************************
   // Decode into one of four states
   // ****************************************************************
   always_comb begin
      s1_next = keyswitch_pos;
      s2_next = s1_reg;
      last_next = s2_reg;
      key_next = key_reg;
      if (s2_reg == last_reg) begin
         key_next = kpc_key_t'(s2_reg);
      end
      entry_next = (key_next == KPC_KEY_FORCED_OFF) && (key_reg != KPC_KEY_FORCED_OFF);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg <= KEY_RESET;
         s2_reg <= KEY_RESET;
         last_reg <= KEY_RESET;
         key_reg <= KEY_RESET;
         entry_reg <= 1'b0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         last_reg <= last_next;
         key_reg <= key_next;
         entry_reg <= entry_next;
      end
   end

   assign evt.key_state = key_reg;
   assign evt.forced_entry = entry_reg;
endmodule
`default_nettype wire

// ---- logic/kpc_pkg.sv ----
`default_nettype none
package kpc_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_FREQ_HZ = 125_000_000;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1_000_000) * TICK_TIME_US;
   localparam int DEBOUNCE_TIME_MS = 20;
   localparam int DEBOUNCE_TICKS = (DEBOUNCE_TIME_MS * 1000) / TICK_TIME_US;
   localparam int HOLD_TIME_MS = 5000;
   localparam int HOLD_TICKS = (HOLD_TIME_MS * 1000) / TICK_TIME_US;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
   localparam int CTRL_HOST_RUN_BIT = 0;
   localparam logic CTRL_HOST_RUN_RESET = 1'b0;
   localparam int STAT_KEY_LSB = 0;
   localparam int STAT_POWER_BIT = 2;
   localparam int STAT_SHUTDOWN_BIT = 3;
   localparam int STAT_WAS_RUN_BIT = 4;
   localparam int STAT_REFUSED_BIT = 5;
   localparam int STAT_PRESSED_BIT = 6;
   localparam int STAT_AC_OK_BIT = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      KPC_KEY_NORMAL = 2'b00,
      KPC_KEY_LOCKED = 2'b01,
      KPC_KEY_DIAG = 2'b10,
      KPC_KEY_FORCED_OFF = 2'b11
   } kpc_key_t;
   localparam kpc_key_t KEY_RESET = KPC_KEY_LOCKED;

   typedef enum logic {
      KPC_PWR_OFF = 1'b0,
      KPC_PWR_ON = 1'b1
   } kpc_pwr_t;
endpackage
`default_nettype wire

// ---- logic/kpc_top.sv ----
`default_nettype none
// Summary of operation
// - Normal key: button powers on when off, presses act when on.
// - Short press while host runs raises a graceful shutdown request.
// - Five second hold removes power at once, no software handshake.
// - Locked key: button ignored entirely.
// - Locked key: all four console abort sources suppressed.
// - Locked key: firmware flash write permit deasserted.
// - Diagnostics key: power on self test forced each startup.
// - Entering forced off powers down at once; standby stays on.
// - Remember running state at AC loss; restart on return unless forced off.
// - Forced off refuses remote restarts; management card keeps standby power.
module kpc_top import kpc_pkg::*; #(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int DB_TICKS = DEBOUNCE_TICKS,
   parameter int HLD_TICKS = HOLD_TICKS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_button_n,
   input wire logic [1:0] keyswitch_pos,
   input wire logic ac_power_ok,
   input wire logic kbd_abort,
   input wire logic term_break,
   input wire logic tip_escape,
   input wire logic rmc_break,
   input wire logic remote_management_card_restart,
   output logic system_power_on,
   output logic standby_5v_on,
   output logic shutdown_request,
   output logic console_abort,
   output logic flash_write_permit,
   output logic power_on_self_test_force,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   kpc_evt_if evt ();

   kpc_button #(.TICK_CYC(TICK_CYC), .DB_TICKS(DB_TICKS), .HLD_TICKS(HLD_TICKS)) u_button (
      .aclk(aclk),
      .aresetn(aresetn),
      .power_button_n(power_button_n),
      .evt(evt.btn_src)
   );

   kpc_keyswitch u_key (
      .aclk(aclk),
      .aresetn(aresetn),
      .keyswitch_pos(keyswitch_pos),
      .evt(evt.key_src)
   );

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   logic aw_have_reg, aw_have_next;
   logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
   logic w_have_reg, w_have_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic wr_fire, wr_ctrl, wr_status;
   logic [31:0] status_word;

   // Power group state used by the register file
   kpc_pwr_t pwr_reg, pwr_next;
   logic host_run_reg, host_run_next;
   logic shut_reg, shut_next;
   logic refused_reg, refused_next;
   logic was_run_reg, was_run_next;
   logic [1:0] ac_sync_reg, ac_sync_next;
   logic ac_prev_reg, ac_prev_next;

   always_comb begin
      status_word = '0;
      status_word[STAT_KEY_LSB +: 2] = evt.key_state;
      status_word[STAT_POWER_BIT] = (pwr_reg == KPC_PWR_ON);
      status_word[STAT_SHUTDOWN_BIT] = shut_reg;
      status_word[STAT_WAS_RUN_BIT] = was_run_reg;
      status_word[STAT_REFUSED_BIT] = refused_reg;
      status_word[STAT_PRESSED_BIT] = evt.pressed;
      status_word[STAT_AC_OK_BIT] = ac_prev_reg;
      aw_have_next = aw_have_reg;
      awaddr_next = awaddr_reg;
      w_have_next = w_have_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_axi_awvalid && awready_reg) begin
         aw_have_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
         w_have_next = 1'b1;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
      wr_ctrl = wr_fire && (awaddr_reg == CTRL_OFFSET) && wstrb_reg[0];
      wr_status = wr_fire && (awaddr_reg == STATUS_OFFSET) && wstrb_reg[0];
      if (wr_fire) begin
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (awaddr_reg == CTRL_OFFSET || awaddr_reg == STATUS_OFFSET) ?
                      RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      awready_next = !aw_have_next && !bvalid_next;
      wready_next = !w_have_next && !bvalid_next;
      if (s_axi_arvalid && arready_reg) begin
         arready_next = 1'b0;
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         rdata_next = '0;
         if (s_axi_araddr == CTRL_OFFSET) begin
            rdata_next[CTRL_HOST_RUN_BIT] = host_run_reg;
         end else if (s_axi_araddr == STATUS_OFFSET) begin
            rdata_next = status_word;
         end else begin
            rresp_next = RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
         arready_next = 1'b1;
      end
      arready_next = !rvalid_next && (arready_next || !rvalid_reg);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         awaddr_reg <= '0;
         w_have_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else begin
         aw_have_reg <= aw_have_next;
         awaddr_reg <= awaddr_next;
         w_have_reg <= w_have_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // ****************************************************************
   // Power control
   // ****************************************************************
   logic btn_en, locked, forced, diag, ac_ok, ac_rise, ac_fall;
   logic std_reg, std_next;
   logic abort_reg, abort_next;
   logic flash_reg, flash_next;
   logic diag_reg, diag_next;

   always_comb begin
      ac_sync_next = {ac_sync_reg[0], ac_power_ok};
      ac_ok = ac_sync_reg[1];
      ac_prev_next = ac_ok;
      ac_rise = ac_ok && !ac_prev_reg;
      ac_fall = !ac_ok && ac_prev_reg;
      locked = (evt.key_state == KPC_KEY_LOCKED);
      forced = (evt.key_state == KPC_KEY_FORCED_OFF);
      diag = (evt.key_state == KPC_KEY_DIAG);
      btn_en = (evt.key_state == KPC_KEY_NORMAL) || diag;
      pwr_next = pwr_reg;
      shut_next = shut_reg;
      refused_next = refused_reg;
      host_run_next = wr_ctrl ? wdata_reg[CTRL_HOST_RUN_BIT] : host_run_reg;
      was_run_next = ac_ok ? (pwr_reg == KPC_PWR_ON) : was_run_reg;
      if (wr_status && wdata_reg[STAT_SHUTDOWN_BIT]) begin
         shut_next = 1'b0;
      end
      if (wr_status && wdata_reg[STAT_REFUSED_BIT]) begin
         refused_next = 1'b0;
      end
      if (ac_fall || !ac_ok) begin
         pwr_next = KPC_PWR_OFF;
      end else if (forced || evt.forced_entry) begin
         pwr_next = KPC_PWR_OFF;
      end else if (btn_en && evt.long_press && pwr_reg == KPC_PWR_ON) begin
         pwr_next = KPC_PWR_OFF;
      end else if (btn_en && evt.short_press && pwr_reg == KPC_PWR_OFF) begin
         pwr_next = KPC_PWR_ON;
      end else if (ac_rise && was_run_reg) begin
         pwr_next = KPC_PWR_ON;
      end else if (remote_management_card_restart) begin
         pwr_next = KPC_PWR_ON;
      end
      if (btn_en && evt.short_press && pwr_reg == KPC_PWR_ON && host_run_reg) begin
         shut_next = 1'b1;
      end
      if (remote_management_card_restart && forced) begin
         refused_next = 1'b1;
      end
      std_next = 1'b1;
      abort_next = !locked && (kbd_abort || term_break || tip_escape || rmc_break);
      flash_next = !locked;
      diag_next = diag;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_reg <= KPC_PWR_OFF;
         host_run_reg <= CTRL_HOST_RUN_RESET;
         shut_reg <= 1'b0;
         refused_reg <= 1'b0;
         was_run_reg <= 1'b0;
         ac_sync_reg <= '0;
         ac_prev_reg <= 1'b0;
         std_reg <= 1'b0;
         abort_reg <= 1'b0;
         flash_reg <= 1'b0;
         diag_reg <= 1'b0;
      end else begin
         pwr_reg <= pwr_next;
         host_run_reg <= host_run_next;
         shut_reg <= shut_next;
         refused_reg <= refused_next;
         was_run_reg <= was_run_next;
         ac_sync_reg <= ac_sync_next;
         ac_prev_reg <= ac_prev_next;
         std_reg <= std_next;
         abort_reg <= abort_next;
         flash_reg <= flash_next;
         diag_reg <= diag_next;
      end
   end

   assign system_power_on = (pwr_reg == KPC_PWR_ON);
   assign standby_5v_on = std_reg;
   assign shutdown_request = shut_reg;
   assign console_abort = abort_reg;
   assign flash_write_permit = flash_reg;
   assign power_on_self_test_force = diag_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
endmodule
`default_nettype wire

// ---- tb/kpc_bench.sv ----
`default_nettype none
module kpc_bench import kpc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic press = 1'b0;
   logic [1:0] key_sel = 2'h0;
   logic ac_power_ok = 1'b1;
   logic [3:0] abort_v = 4'h0;
   logic remote_management_card_restart = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire logic power_button_n, system_power_on, standby_5v_on, shutdown_request;
   wire logic console_abort, flash_write_permit, power_on_self_test_force;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] keyswitch_pos, s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   logic [31:0] d;
   logic [1:0] r;
   int num_errors = 0;
   int total_checks = 0;
   kpc_panel_model kpc_panel_model_inst (.aclk(aclk), .press(press), .key_sel(key_sel),
      .power_button_n(power_button_n), .keyswitch_pos(keyswitch_pos));
   kpc_top #(.TICK_CYC(4), .DB_TICKS(2), .HLD_TICKS(10)) kpc_top_inst (.aclk(aclk),
      .aresetn(aresetn), .power_button_n(power_button_n), .keyswitch_pos(keyswitch_pos),
      .ac_power_ok(ac_power_ok), .kbd_abort(abort_v[0]), .term_break(abort_v[1]),
      .tip_escape(abort_v[2]), .rmc_break(abort_v[3]),
      .remote_management_card_restart(remote_management_card_restart),
      .system_power_on(system_power_on), .standby_5v_on(standby_5v_on),
      .shutdown_request(shutdown_request), .console_abort(console_abort),
      .flash_write_permit(flash_write_permit),
      .power_on_self_test_force(power_on_self_test_force),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   initial begin
      forever #4 aclk = ~aclk;
   end
   // ****
   // Helpers
   // ****
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            break;
         end
      end
      s_axi_bready <= 1'b0;
   endtask
   task axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            v = s_axi_rdata;
            resp = s_axi_rresp;
            break;
         end
      end
      s_axi_rready <= 1'b0;
   endtask
   task push(input int n);
      press <= 1'b1;
      tick(n);
      press <= 1'b0;
      tick(40);
   endtask
   task set_key(input logic [1:0] k);
      key_sel <= k;
      tick(12);
   endtask
   task remote_pulse;
      remote_management_card_restart <= 1'b1;
      tick(1);
      remote_management_card_restart <= 1'b0;
      tick(8);
   endtask
   task report_and_stop;
      if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   task t_regs;
      axi_rd(4'h0, d, r);
      chk("ctrl", 32'h0, d);
      axi_rd(4'h4, d, r);
      chk("status", 32'h80, d);
      axi_rd(4'h8, d, r);
      chk("rd resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi_wr(4'hc, 32'h1, r);
      chk("wr resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      s_axi_wstrb <= 4'h0;
      axi_wr(4'h0, 32'h1, r);
      s_axi_wstrb <= 4'hf;
      axi_rd(4'h0, d, r);
      chk("masked wr", 32'h0, d);
      chk("standby", 1, standby_5v_on);
   endtask
   task t_normal;
      push(24);
      chk("on by short", 1, system_power_on);
      axi_wr(4'h0, 32'h1, r);
      axi_rd(4'h0, d, r);
      chk("host run", 1, d);
      push(24);
      chk("shutdown", 1, shutdown_request);
      chk("still on", 1, system_power_on);
      axi_wr(4'h4, 32'h8, r);
      chk("shut clear", 0, shutdown_request);
      push(70);
      chk("long off", 0, system_power_on);
      chk("no shut", 0, shutdown_request);
   endtask
   task t_diag;
      set_key(2'h2);
      chk("power_on_self_test", 1, power_on_self_test_force);
      push(24);
      chk("diag on", 1, system_power_on);
      push(70);
      chk("diag off", 0, system_power_on);
      set_key(2'h0);
      chk("power_on_self_test off", 0, power_on_self_test_force);
   endtask
   task t_locked;
      for (int k = 0; k < 2; k++) begin
         set_key(k[0] ? 2'h0 : 2'h1);
         chk("flash", {31'h0, k[0]}, flash_write_permit);
         for (int i = 0; i < 4; i++) begin
            abort_v <= 4'h1 << i;
            tick(3);
            chk("abort", {31'h0, k[0]}, console_abort);
            abort_v <= 4'h0;
            tick(2);
         end
      end
      set_key(2'h1);
      push(24);
      chk("locked stays off", 0, system_power_on);
      set_key(2'h0);
      push(24);
      set_key(2'h1);
      push(70);
      chk("locked stays on", 1, system_power_on);
      chk("locked no shut", 0, shutdown_request);
   endtask
   task t_forced;
      set_key(2'h3);
      chk("forced off", 0, system_power_on);
      chk("standby kept", 1, standby_5v_on);
      push(24);
      chk("btn ignored", 0, system_power_on);
      remote_pulse();
      chk("remote refused", 0, system_power_on);
      axi_rd(4'h4, d, r);
      chk("refused flag", 1, d[STAT_REFUSED_BIT]);
      for (int k = 0; k < 4; k++) begin
         set_key(k[1:0]);
         axi_rd(4'h4, d, r);
         chk("key state", k, d[1:0]);
      end
   endtask
   task t_ac;
      set_key(2'h0);
      remote_pulse();
      chk("remote on", 1, system_power_on);
      ac_power_ok <= 1'b0;
      tick(12);
      chk("ac lost", 0, system_power_on);
      axi_rd(4'h4, d, r);
      chk("was running", 1, d[STAT_WAS_RUN_BIT]);
      chk("power bit", 0, d[STAT_POWER_BIT]);
      ac_power_ok <= 1'b1;
      tick(12);
      chk("ac restart", 1, system_power_on);
      ac_power_ok <= 1'b0;
      set_key(2'h3);
      ac_power_ok <= 1'b1;
      tick(12);
      chk("forced no restart", 0, system_power_on);
   endtask
   initial begin
      tick(8);
      aresetn <= 1'b1;
      tick(8);
      t_regs();
      t_normal();
      t_diag();
      t_locked();
      t_forced();
      t_ac();
      report_and_stop();
   end
   initial begin
      tick(20000);
      num_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire

// ---- tb/kpc_panel_model.sv ----
`default_nettype none
// ****
// Front panel: button with contact bounce, keyswitch
// ****
module kpc_panel_model (
   input wire logic aclk,
   input wire logic press,
   input wire logic [1:0] key_sel,
   output logic power_button_n,
   output logic [1:0] keyswitch_pos
);
   timeunit 1ns;
   timeprecision 1ps;
   logic press_reg = 1'b0;
   logic [1:0] bounce_reg = 2'h0;
   logic btn_reg = 1'b1;
   logic [1:0] key_reg = 2'h0;
   always @(posedge aclk) begin
      press_reg <= press;
      key_reg <= key_sel;
      if (press != press_reg) begin
         bounce_reg <= 2'h3;
      end else if (bounce_reg != 2'h0) begin
         bounce_reg <= bounce_reg - 2'h1;
      end
      // Contact chatters for a few cycles on each change
      btn_reg <= (bounce_reg != 2'h0) ? ~btn_reg : ~press_reg;
   end
   assign power_button_n = btn_reg;
   assign keyswitch_pos = key_reg;
endmodule
`default_nettype wire

// ---- tb/kpc_top_properties.sv ----
`default_nettype none
module kpc_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] keyswitch_pos,
   input wire logic ac_power_ok,
   input wire logic kbd_abort,
   input wire logic term_break,
   input wire logic tip_escape,
   input wire logic rmc_break,
   input wire logic remote_management_card_restart,
   input wire logic system_power_on,
   input wire logic standby_5v_on,
   input wire logic shutdown_request,
   input wire logic console_abort,
   input wire logic flash_write_permit,
   input wire logic power_on_self_test_force,
   input wire logic s_axi_wready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_lock_gate: assert property ((keyswitch_pos == 2'h1) [*8] |->
      !console_abort && !flash_write_permit) else $error("locked key leaves abort or flash open");
   a_diag_force: assert property ((keyswitch_pos == 2'h2) [*8] |->
      power_on_self_test_force) else $error("diagnostics key without self test force");
   a_forced_off: assert property ((keyswitch_pos == 2'h3) [*8] |->
      !system_power_on) else $error("power on in forced off");
   a_standby_up: assert property ($past(aresetn) |-> standby_5v_on)
      else $error("standby supply off");
   a_abort_pass: assert property ((keyswitch_pos == 2'h0) [*8] ##0
      (kbd_abort || term_break || tip_escape || rmc_break) |=> console_abort)
      else $error("abort not passed in normal key");
   a_ac_loss_off: assert property ((!ac_power_ok) [*5] |-> !system_power_on)
      else $error("power on without AC");
   a_locked_hold: assert property ((keyswitch_pos == 2'h1 && ac_power_ok &&
      !remote_management_card_restart) [*8] |-> $stable(system_power_on))
      else $error("power changed while locked");
   a_shut_kept: assert property (shutdown_request && s_axi_wready |=> shutdown_request)
      else $error("shutdown request dropped");
endmodule
bind kpc_top kpc_props kpc_props_inst (.aclk(aclk), .aresetn(aresetn),
   .keyswitch_pos(keyswitch_pos), .ac_power_ok(ac_power_ok), .kbd_abort(kbd_abort),
   .term_break(term_break), .tip_escape(tip_escape), .rmc_break(rmc_break),
   .remote_management_card_restart(remote_management_card_restart),
   .system_power_on(system_power_on), .standby_5v_on(standby_5v_on),
   .shutdown_request(shutdown_request), .console_abort(console_abort),
   .flash_write_permit(flash_write_permit),
   .power_on_self_test_force(power_on_self_test_force), .s_axi_wready(s_axi_wready));
`default_nettype wire
